// [modulo_timer.sv]
// modulo timer with prescaler, apb registers and interrupt output
`include "modulo_timer_defs.svh"
`default_nettype none
module modulo_timer
    import modulo_timer_pkg::*;
(
    // clock, reset, enable
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic        CLK_EN,
    // external source clocks, asynchronous
    input  wire logic [2:0]  EXT_CLK,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // interrupt
    output logic             IRQ
);
    // ==========================================================
    // state
    sc_bits_t    sc_reg;
    clk_cfg_t    ck_reg;
    timer_mode_t mode_reg;
    logic [7:0]  count_reg;
    logic [7:0]  mod_reg;
    logic [7:0]  pre_reg;
    logic [2:0]  ext_s1_reg;
    logic [2:0]  ext_s2_reg;
    logic [2:0]  ext_s3_reg;
    logic        irq_st_reg;
    logic        irq_en_reg;
    logic        rd_stat_reg;

    // ==========================================================
    // apb decode
    wire logic acc      = PSEL & PENABLE & CLK_EN;
    wire logic wr       = acc & PWRITE;
    wire logic rd       = acc & ~PWRITE;
    wire logic hit_sc   = PADDR == `ADDR_STATUS_CONTROL;
    wire logic hit_ck   = PADDR == `ADDR_CLOCK_CONFIG;
    wire logic hit_cnt  = PADDR == `ADDR_COUNT_VALUE;
    wire logic hit_mod  = PADDR == `ADDR_COMPARE_VALUE;
    wire logic hit_pnd  = PADDR == `ADDR_IRQ_PENDING;
    wire logic hit_mode = PADDR == `ADDR_MODE;
    wire logic hit_ist  = PADDR == `ADDR_IRQ_STATUS;
    wire logic hit_ien  = PADDR == `ADDR_IRQ_ENABLE;
    wire logic hit_icl  = PADDR == `ADDR_IRQ_CLEAR;
    wire logic mapped   = hit_sc | hit_ck | hit_cnt | hit_mod | hit_pnd | hit_mode
                        | hit_ist | hit_ien | hit_icl;
    wire logic wr_sc    = wr & hit_sc;
    wire logic wr_cnt   = wr & hit_cnt;
    wire logic wr_mod   = wr & hit_mod;
    wire logic cnt_rst  = wr_sc & PWDATA[`SC_RST_BIT];

    // ==========================================================
    // source selection: bus clock or a synchronised external edge
    wire logic [2:0] ext_rise = ext_s2_reg & ~ext_s3_reg;
    wire logic src_tick = (ck_reg.clock_source_select == `SRC_BUS) ? 1'b1
                        : ext_rise[ck_reg.clock_source_select - 2'h1];

    // prescaler: tick when the low ps bits of the divider wrap
    wire logic [8:0] ps_mask = (9'h001 << ck_reg.prescale_select) - 9'h001;
    wire logic [7:0] pre_next = pre_reg + 8'h01;
    wire logic pre_tick = src_tick & ((pre_reg & ps_mask[7:0]) == ps_mask[7:0]);
    wire logic running  = ~sc_reg.counter_stop_bit & (mode_reg != MODE_STOP);
    wire logic cnt_tick = pre_tick & running;

    // match and wrap
    wire logic match     = (mode_reg == MODE_MODULO) ? (count_reg == mod_reg)
                                                     : (count_reg == 8'hff);
    wire logic overflow  = cnt_tick & match;
    wire logic [7:0] count_next = overflow ? 8'h00 : count_reg + 8'h01;
    wire logic flag_clr = wr_sc & rd_stat_reg & ~PWDATA[`SC_FLAG_BIT];

    // ==========================================================
    // read mux
    wire logic [7:0] sc_rd = {sc_reg.overflow_flag, sc_reg.overflow_irq_enable, 1'b0,
                              sc_reg.counter_stop_bit, 4'h0};
    wire logic [7:0] pnd_rd = {5'h00, sc_reg.overflow_flag & sc_reg.overflow_irq_enable,
                               2'h0};
    wire logic [31:0] rd_mux =
          hit_sc   ? {24'h0, sc_rd}
        : hit_ck   ? {24'h0, 2'h0, ck_reg}
        : hit_cnt  ? {24'h0, count_reg}
        : hit_mod  ? {24'h0, mod_reg}
        : hit_pnd  ? {24'h0, pnd_rd}
        : hit_mode ? {30'h0, mode_reg}
        : hit_ist  ? {31'h0, irq_st_reg}
        : hit_ien  ? {31'h0, irq_en_reg}
        : 32'h0;

    // ==========================================================
    // synchronisers for the external sources
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            ext_s1_reg <= 3'h0;
            ext_s2_reg <= 3'h0;
            ext_s3_reg <= 3'h0;
        end
        else if (CLK_EN)
        begin
            ext_s1_reg <= EXT_CLK;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // prescaler divider, cleared by a counter reset or a count write, not by a compare write
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
            pre_reg <= 8'h00;
        else if (CLK_EN)
        begin
            if (cnt_rst || wr_cnt)
                pre_reg <= 8'h00;
            else if (src_tick && running)
                pre_reg <= pre_next;
        end
    end

    // counter
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
            count_reg <= 8'h00;
        else if (CLK_EN)
        begin
            if (cnt_rst || wr_cnt || wr_mod)
                count_reg <= 8'h00;
            else if (cnt_tick)
                count_reg <= count_next;
        end
    end

    // status/control; a new overflow beats a clear
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
            sc_reg <= sc_bits_t'(3'h1);
        else if (CLK_EN)
        begin
            if (wr_sc)
            begin
                sc_reg.overflow_irq_enable <= PWDATA[`SC_IE_BIT];
                sc_reg.counter_stop_bit    <= PWDATA[`SC_STOP_BIT];
            end
            if (overflow)
                sc_reg.overflow_flag <= 1'b1;
            else if (flag_clr)
                sc_reg.overflow_flag <= 1'b0;
        end
    end

    // read of status with flag set arms the clear
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
            rd_stat_reg <= 1'b0;
        else if (CLK_EN)
        begin
            if (rd && hit_sc)
                rd_stat_reg <= sc_reg.overflow_flag;
            else if (wr_sc)
                rd_stat_reg <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            ck_reg   <= clk_cfg_t'(`CK_RESET);
            mod_reg  <= `MOD_RESET;
            mode_reg <= MODE_MODULO;
        end
        else if (CLK_EN)
        begin
            if (wr && hit_ck)
                ck_reg <= clk_cfg_t'({PWDATA[5:4],
                          (PWDATA[3:0] > `PS_MAX) ? `PS_MAX : PWDATA[3:0]});
            if (wr_mod)
                mod_reg <= PWDATA[7:0];
            if (wr && hit_mode && PWDATA[1:0] != 2'h3)
                mode_reg <= timer_mode_t'(PWDATA[1:0]);
        end
    end

    // interrupt status, enable and clear; set wins over clear
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            irq_st_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            IRQ        <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (overflow && sc_reg.overflow_irq_enable)
                irq_st_reg <= 1'b1;
            else if (wr && hit_icl && PWDATA[0])
                irq_st_reg <= 1'b0;
            if (wr && hit_ien)
                irq_en_reg <= PWDATA[0];
            IRQ <= irq_st_reg & irq_en_reg;
        end
    end

    // apb answer: one wait-free access phase
    always_ff @(posedge SYS_CLK)
    begin
        if (!NRST)
        begin
            PRDATA  <= 32'h0;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else if (CLK_EN)
        begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            if (PSEL && !PENABLE && !PWRITE)
                PRDATA <= rd_mux;
        end
    end

    // ==========================================================
    // checks
    chk_stop_holds: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && sc_reg.counter_stop_bit && !wr_cnt && !cnt_rst && !wr_mod
        |=> $stable(count_reg)) else $error("count moved while stopped");
    chk_count_step: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && cnt_tick && !match && !cnt_rst && !wr_cnt && !wr_mod
        |=> count_reg == $past(count_reg) + 8'h01) else $error("count step wrong");
    chk_wrap_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && overflow && !cnt_rst && !wr_cnt && !wr_mod
        |=> count_reg == 8'h00) else $error("no wrap after match");
    chk_flag_set: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && overflow |=> sc_reg.overflow_flag) else $error("flag not set");
    chk_reset_cnt: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        cnt_rst |=> count_reg == 8'h00 && pre_reg == 8'h00) else $error("reset failed");
    chk_pending: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && !PENABLE && !PWRITE && hit_pnd
        |=> PRDATA[`PENDING_BIT] == $past(sc_reg.overflow_flag && sc_reg.overflow_irq_enable))
        else $error("pending bit wrong");
    chk_ps_range: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        ck_reg.prescale_select <= `PS_MAX) else $error("prescale out of range");
    // a mode change may leave the count above compare; only a count inside stays inside
    chk_no_count_limit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && mode_reg == MODE_MODULO && count_reg <= mod_reg && !wr_mod
        |=> count_reg <= mod_reg || $changed(mod_reg)) else $error("count beyond compare");
    chk_irq_follow: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && irq_st_reg && irq_en_reg |=> IRQ) else $error("irq missing");
    chk_irq_masked: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && !irq_en_reg |=> !IRQ) else $error("irq while masked");
    chk_irq_status: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && overflow && sc_reg.overflow_irq_enable |=> irq_st_reg)
        else $error("irq status not set");

    // ==========================================================
    // bus answer checks
    chk_ready_setup: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && !PENABLE |=> PREADY) else $error("ready missing");
    chk_ready_once: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && PENABLE |=> !PREADY) else $error("ready held too long");
    chk_err_unmapped: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && !PENABLE && !mapped |=> PSLVERR) else $error("error missing");
    chk_err_mapped: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && !PENABLE && mapped |=> !PSLVERR) else $error("false error");
    chk_read_count: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && !PENABLE && !PWRITE && hit_cnt
        |=> PRDATA == {24'h0, $past(count_reg)}) else $error("count read wrong");
    chk_read_flag: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && PSEL && !PENABLE && !PWRITE && hit_sc
        |=> PRDATA[`SC_FLAG_BIT] == $past(sc_reg.overflow_flag)) else $error("flag read wrong");

    // ==========================================================
    // control register checks
    chk_ie_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wr_sc |=> sc_reg.overflow_irq_enable == $past(PWDATA[`SC_IE_BIT]))
        else $error("irq enable write lost");
    chk_stop_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wr_sc |=> sc_reg.counter_stop_bit == $past(PWDATA[`SC_STOP_BIT]))
        else $error("stop write lost");
    chk_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        flag_clr && !overflow |=> !sc_reg.overflow_flag) else $error("flag not cleared");
    chk_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        sc_reg.overflow_flag && !flag_clr |=> sc_reg.overflow_flag)
        else $error("flag dropped by itself");
    chk_mod_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wr_mod |=> mod_reg == $past(PWDATA[7:0]) && count_reg == 8'h00)
        else $error("compare write wrong");
    chk_cnt_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wr_cnt |=> count_reg == 8'h00 && pre_reg == 8'h00) else $error("count write wrong");
    chk_ps_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wr && hit_ck && PWDATA[3:0] <= `PS_MAX
        |=> ck_reg.prescale_select == $past(PWDATA[3:0])) else $error("prescale write lost");
    chk_mode_refuse: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        wr && hit_mode && PWDATA[1:0] == 2'h3 |=> $stable(mode_reg))
        else $error("illegal mode taken");

    // ==========================================================
    // counting checks
    chk_ext_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        ck_reg.clock_source_select != `SRC_BUS && ext_rise == 3'h0 |-> !pre_tick)
        else $error("tick without source edge");
    chk_free_wrap: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        CLK_EN && cnt_tick && mode_reg == MODE_FREE && count_reg == 8'hff
        && !cnt_rst && !wr_cnt && !wr_mod |=> count_reg == 8'h00) else $error("free no wrap");
    chk_freeze_count: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !CLK_EN |=> $stable(count_reg)) else $error("count moved while frozen");
    chk_freeze_irq: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        !CLK_EN |=> $stable(IRQ)) else $error("irq moved while frozen");

    // ==========================================================
    // coverage of the main scenarios
    cov_overflow:  cover property (@(posedge SYS_CLK) overflow);
    cov_flag_clr:  cover property (@(posedge SYS_CLK) flag_clr);
    cov_free:      cover property (@(posedge SYS_CLK) overflow && mode_reg == MODE_FREE);
    cov_ext_tick:  cover property (@(posedge SYS_CLK) cnt_tick && ck_reg.clock_source_select != `SRC_BUS);
    cov_freeze:    cover property (@(posedge SYS_CLK) !CLK_EN && running);
endmodule : modulo_timer
`default_nettype wire

// [modulo_timer_defs.svh]
// constant definitions for the 8-bit modulo timer
`ifndef MODULO_TIMER_DEFS_SVH
`define MODULO_TIMER_DEFS_SVH
// ==========================================================
// register byte addresses
`define ADDR_STATUS_CONTROL 12'h000
`define ADDR_CLOCK_CONFIG   12'h004
`define ADDR_COUNT_VALUE    12'h008
`define ADDR_COMPARE_VALUE  12'h00c
`define ADDR_IRQ_PENDING    12'h010
`define ADDR_MODE           12'h014
`define ADDR_IRQ_STATUS     12'h018
`define ADDR_IRQ_ENABLE     12'h01c
`define ADDR_IRQ_CLEAR      12'h020
// ==========================================================
// field positions
`define SC_FLAG_BIT    7
`define SC_IE_BIT      6
`define SC_RST_BIT     5
`define SC_STOP_BIT    4
`define CK_SRC_LSB     4
`define PS_MAX         4'h8
`define PENDING_BIT    2
// ==========================================================
// reset values
`define SC_RESET       8'h10
`define CK_RESET       8'h00
`define MOD_RESET      8'h00
`define SRC_BUS        2'h0
`endif

// [modulo_timer_pkg.sv]
// types shared by the modulo timer
`default_nettype none
package modulo_timer_pkg;
    typedef enum logic [1:0] {MODE_MODULO, MODE_FREE, MODE_STOP} timer_mode_t;
    typedef struct packed {
        logic       overflow_flag;
        logic       overflow_irq_enable;
        logic       counter_stop_bit;
    } sc_bits_t;
    typedef struct packed {
        logic [1:0] clock_source_select;
        logic [3:0] prescale_select;
    } clk_cfg_t;
endpackage : modulo_timer_pkg
`default_nettype wire

// [test_modulo_timer.sv]
// self-checking testbench for the modulo timer
`include "modulo_timer_defs.svh"
`default_nettype none
module test_modulo_timer
    import modulo_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // bench signals
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ce = 1;
    logic        pready, perr, irq, e;
    logic [2:0]  ext = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    int          fails = 0, samples_checked = 0, cyc = 0, t0;
    // clock, cycle count, slow external source
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (cyc % 4 == 0) ext[0] <= ~ext[0];
    modulo_timer DUT (.SYS_CLK(clk), .NRST(rst_n), .CLK_EN(ce), .EXT_CLK(ext),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .IRQ(irq));
    // ==========================================
    // shared tasks
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // one apb transfer: setup, access until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = perr;
        if (n >= 20) begin fails++; end_of_test(); end
        psel <= 0; pen <= 0;
    endtask : apb
    task rd(input string n, input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        chk(n, x, r);
    endtask : rd
    // poll status until the overflow flag shows, bounded
    task to_flag;
        int k;
        k = 0;
        do begin apb(0, 12'h000, 0); k++; end while (r[7] !== 1'b1 && k < 200);
        if (k >= 200) begin fails++; end_of_test(); end
    endtask : to_flag
    // ==========================================
    // scenarios
    task t_reset;
        rd("status", 12'h000, 32'h10);
        rd("clkcfg", 12'h004, 32'h0);
        rd("compare", 12'h00c, 32'h0);
        rd("count", 12'h008, 32'h0);
        apb(0, 12'h100, 0);
        chk("unmapped err", 1, e);
        chk("unmapped data", 0, r);
    endtask : t_reset
    task t_modulo;
        apb(1, 12'h01c, 1);
        apb(1, 12'h00c, 32'hff);
        apb(1, 12'h000, 32'h70);
        rd("sc after 70", 12'h000, 32'h50);
        repeat (20) @(posedge clk);
        rd("stopped count", 12'h008, 32'h0);
        apb(1, 12'h004, 32'h0);
        apb(1, 12'h000, 32'h40);
        t0 = cyc;
        to_flag();
        chk("period ff", 1, (cyc - t0 >= 250 && cyc - t0 <= 266));
        apb(0, 12'h008, 0);
        chk("wrap", 1, r < 8);
        rd("pending", 12'h010, 32'h4);
        chk("irq", 1, irq);
    endtask : t_modulo
    task t_clear;
        apb(0, 12'h000, 0);
        apb(1, 12'h000, 32'h60);
        rd("sc cleared", 12'h000, 32'h40);
        rd("pending off", 12'h010, 32'h0);
        rd("irq status", 12'h018, 32'h1);
        apb(1, 12'h020, 1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 0, irq);
        apb(1, 12'h01c, 0);
        to_flag();
        repeat (2) @(posedge clk);
        chk("irq masked", 0, irq);
        apb(1, 12'h01c, 1);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 1, irq);
        apb(1, 12'h020, 1);
    endtask : t_clear
    task t_modes;
        logic [31:0] c;
        apb(1, 12'h014, 1);
        apb(1, 12'h00c, 32'h3);
        apb(1, 12'h000, 32'h60);
        repeat (30) @(posedge clk);
        apb(0, 12'h008, 0);
        chk("free past compare", 1, r > 3 && r < 60);
        apb(1, 12'h014, 2);
        apb(0, 12'h008, 0);
        c = r;
        repeat (20) @(posedge clk);
        rd("stop mode", 12'h008, c);
        apb(1, 12'h014, 0);
    endtask : t_modes
    task t_prescale;
        apb(1, 12'h00c, 32'hff);
        apb(1, 12'h004, 32'h08);
        rd("clkcfg 08", 12'h004, 32'h08);
        apb(1, 12'h000, 32'h60);
        repeat (520) @(posedge clk);
        apb(0, 12'h008, 0);
        chk("div 256", 1, r >= 1 && r <= 3);
        apb(1, 12'h004, 32'h01);
        apb(1, 12'h000, 32'h60);
        repeat (40) @(posedge clk);
        apb(0, 12'h008, 0);
        chk("div 2", 1, r >= 18 && r <= 23);
    endtask : t_prescale
    task t_ext;
        apb(1, 12'h004, 32'h10);
        apb(1, 12'h000, 32'h60);
        repeat (80) @(posedge clk);
        apb(0, 12'h008, 0);
        chk("ext source", 1, r >= 7 && r <= 12);
    endtask : t_ext
    // clock enable low freezes the running counter
    task t_freeze;
        logic [31:0] c;
        apb(1, 12'h004, 32'h0);
        apb(0, 12'h008, 0);
        c = r;
        ce <= 0;
        repeat (40) @(posedge clk);
        ce <= 1;
        apb(0, 12'h008, 0);
        chk("frozen count", 1, ((r - c) & 32'hff) <= 8);
    endtask : t_freeze
    // ==========================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        t_reset();
        t_modulo();
        t_clear();
        t_modes();
        t_prescale();
        t_ext();
        t_freeze();
        end_of_test();
    end
endmodule : test_modulo_timer
`default_nettype wire
